// >>> verilog/uib_pkg.sv
package uib_pkg;

    // Register byte addresses on the parallel bus
    localparam logic [7:0] UIB_ADDR_PORT_A_LOW = 8'h14;
    localparam logic [7:0] UIB_ADDR_PORT_B_LOW = 8'h1C;
    localparam logic [7:0] UIB_ADDR_BID_BREAK = 8'h50;
    localparam logic [7:0] UIB_ADDR_BID_PIN = 8'h51;
    localparam logic [7:0] UIB_ADDR_BID_TIMER = 8'h52;
    localparam logic [7:0] UIB_ADDR_BID_FLOW = 8'h53;
    localparam logic [7:0] UIB_ADDR_BID_ADDR = 8'h54;
    localparam logic [7:0] UIB_ADDR_BID_LOOP = 8'h55;
    localparam logic [7:0] UIB_ADDR_UPDATE_CTX = 8'h61;
    localparam logic [7:0] UIB_ADDR_KIND = 8'h72;
    localparam logic [7:0] UIB_ADDR_DATA_PORT = 8'h73;

    // Reset values
    localparam logic [7:0] UIB_BID_RESET = 8'h00;
    localparam logic [7:0] UIB_DATA_RESET = 8'h00;

    // Kind register fields
    localparam int UIB_KIND_RX_MSB = 7;
    localparam int UIB_KIND_RX_LSB = 6;
    localparam int UIB_KIND_TX_BIT = 5;
    localparam int UIB_KIND_OTHER_MSB = 2;
    localparam logic [1:0] UIB_RX_WITH_ERR = 2'h2;
    localparam logic [1:0] UIB_RX_NO_ERR = 2'h3;

    // Other-type codes
    localparam logic [2:0] UIB_OTHER_NONE = 3'h0;
    localparam logic [2:0] UIB_OTHER_PIN = 3'h1;
    localparam logic [2:0] UIB_OTHER_ADDR = 3'h2;
    localparam logic [2:0] UIB_OTHER_FLOW = 3'h3;
    localparam logic [2:0] UIB_OTHER_WDOG = 3'h4;
    localparam logic [2:0] UIB_OTHER_BREAK = 3'h5;
    localparam logic [2:0] UIB_OTHER_TIMER = 3'h6;
    localparam logic [2:0] UIB_OTHER_LOOP = 3'h7;

    // Port nibble layout and pins present on each port
    localparam int UIB_NIB = 4;
    localparam int UIB_FLAG_LSB = 4;
    localparam logic [3:0] UIB_PINS_A = 4'hF;
    localparam logic [3:0] UIB_PINS_B = 4'hD;

    // Character length codes: 5, 6, 7, 8 data bits
    localparam logic [1:0] UIB_LEN5 = 2'h0;
    localparam logic [1:0] UIB_LEN6 = 2'h1;
    localparam logic [1:0] UIB_LEN7 = 2'h2;

    // Arbitration sources
    localparam int UIB_NSRC = 10;
    localparam int UIB_BID_W = 10;
    typedef enum logic [3:0] {
        UIB_SRC_RX, UIB_SRC_TX, UIB_SRC_PIN, UIB_SRC_ADDR, UIB_SRC_FLOW,
        UIB_SRC_WDOG, UIB_SRC_BREAK, UIB_SRC_TIMER0, UIB_SRC_TIMER1, UIB_SRC_LOOP
    } uib_src_t;

    // Fixed low bid bits for register-bid sources
    localparam logic [1:0] UIB_LOW_BID = 2'h0;
    localparam logic [1:0] UIB_LOW_BID_T1 = 2'h1;

endpackage

// >>> verilog/uib_pin_if.sv
interface uib_pin_if;
    logic [3:0] level;
    logic [3:0] change_en;
    logic [3:0] is_output;
    logic read_clear;
    logic [3:0] flags;
    logic [3:0] levels;

    modport owner (
        output level,
        output change_en,
        output is_output,
        output read_clear,
        input flags,
        input levels
    );

    modport detector (
        input level,
        input change_en,
        input is_output,
        input read_clear,
        output flags,
        output levels
    );
endinterface

// >>> verilog/uib_pin_change.sv
module uib_pin_change
    import uib_pkg::*;
#(
    parameter logic [3:0] PRESENT = 4'hF
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    uib_pin_if.detector pins
);

    logic armed_reg;

    // First edge after reset only loads the pin history, so no false change
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < UIB_NIB; i++) begin : g_pin
            if (PRESENT[i]) begin : g_live
                logic prev_reg;
                logic sticky_reg;
                always_ff @(posedge clk_in or negedge reset_n_in) begin
                    if (!reset_n_in) begin
                        prev_reg <= 1'b0;
                    end else begin
                        prev_reg <= pins.level[i];
                    end
                end
                // Sticky change flag, a new change beats the read clear
                always_ff @(posedge clk_in or negedge reset_n_in) begin
                    if (!reset_n_in) begin
                        sticky_reg <= 1'b0;
                    end else if (armed_reg && (pins.level[i] != prev_reg)) begin
                        sticky_reg <= 1'b1; // RL18
                    end else if (pins.read_clear) begin
                        sticky_reg <= 1'b0; // RL18
                    end
                end
                // Hidden when detection is off or the pin drives out
                assign pins.flags[i] = sticky_reg & pins.change_en[i] & ~pins.is_output[i]; // RL14
                assign pins.levels[i] = prev_reg;
            end else begin : g_absent
                assign pins.flags[i] = 1'b0; // RL15
                assign pins.levels[i] = 1'b0; // RL15
            end
        end
    endgenerate

endmodule

// >>> verilog/uib_context_bids.sv
// Contract
// (RL1) Kind bits 7:6 give receiver class: 0x none, 10 with errors, 11 clean.
// (RL2) Kind bit 5 is set for a transmitter interrupt, clear otherwise.
// (RL3) Kind bits 2:0 encode the other interrupt sources, 000 through 111.
// (RL4) Kind register describes the latched context and covers every interrupt kind.
// (RL5) Reading the shared data port pops the latched channel's receive FIFO.
// (RL6) Receive port data is undefined unless the latched context is a receiver.
// (RL7) Unused upper bits read zero for 7, 6 or 5 bit characters.
// (RL8) Writing the shared data port loads the transmit FIFO; excess bits dropped.
// (RL9) Host writes the transmit port only in a transmitter context.
// (RL10) Receive and transmit ports share one address; read receives, write transmits.
// (RL11) Each bid register supplies the upper 8 bits of its source's arbitration number.
// (RL12) Both counter/timers share one bid register for their upper bits.
// (RL13) Port A low register: change flags in 7:4, pin levels in 3:0.
// (RL14) A change flag reads zero when detection is off or pin is output.
// (RL15) Port B low register reports pins 3, 2, 0; bits 5 and 1 reserved.
// (RL16) Context latches at acknowledge cycle start or on the update command.
// (RL17) Bids use register as upper bits; highest pending bid wins.
// (RL18) Change flags stay set until the host reads their register, then clear.
module uib_context_bids
    import uib_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Host parallel bus
    input wire logic cs_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic interrupt_acknowledge_n_in,
    output logic [7:0] rdata_out,
    // Channel FIFO side
    input wire logic [7:0] rx_data_in,
    input wire logic [1:0] char_len_in,
    output logic rx_pop_out,
    output logic tx_push_out,
    output logic [7:0] tx_data_out,
    output logic context_channel_out,
    // Interrupt requests and FIFO-based bids
    input wire logic rx_pend_in,
    input wire logic rx_err_in,
    input wire logic [9:0] rx_bid_in,
    input wire logic tx_pend_in,
    input wire logic [9:0] tx_bid_in,
    input wire logic addr_pend_in,
    input wire logic flow_pend_in,
    input wire logic wdog_pend_in,
    input wire logic break_pend_in,
    input wire logic [1:0] timer_pend_in,
    input wire logic loop_pend_in,
    output logic [7:0] current_interrupt_kind_out,
    // I/O port lower nibbles
    input wire logic [3:0] port_a_level_in,
    input wire logic [3:0] port_a_change_en_in,
    input wire logic [3:0] port_a_is_output_in,
    input wire logic [3:0] port_b_level_in,
    input wire logic [3:0] port_b_change_en_in,
    input wire logic [3:0] port_b_is_output_in,
    output logic pin_change_event_out
);

    uib_pin_if pa_if ();
    uib_pin_if pb_if ();

    logic [7:0] bid_break_change_reg;
    logic [7:0] bid_pin_change_reg;
    logic [7:0] bid_timer_event_reg;
    logic [7:0] bid_flow_control_reg;
    logic [7:0] bid_address_match_reg;
    logic [7:0] bid_loopback_error_reg;
    logic [7:0] kind_reg;
    logic channel_reg;
    logic iack_prev_reg;
    logic pin_event_reg;
    logic [7:0] rdata_reg;
    logic rx_pop_reg;
    logic tx_push_reg;
    logic [7:0] tx_data_reg;

    logic rd_hit;
    logic wr_hit;
    logic latch_now;
    logic [UIB_NSRC-1:0] req;
    logic [UIB_BID_W-1:0] bid [UIB_NSRC];
    logic [UIB_BID_W-1:0] best_bid;
    uib_src_t best_src;
    logic best_valid;
    logic [7:0] kind_next;
    logic channel_next;
    logic [7:0] char_mask;

    assign rd_hit = cs_in & rd_in;
    assign wr_hit = cs_in & wr_in;

    // Port change detectors
    assign pa_if.level = port_a_level_in;
    assign pa_if.change_en = port_a_change_en_in;
    assign pa_if.is_output = port_a_is_output_in;
    assign pa_if.read_clear = rd_hit && (addr_in == UIB_ADDR_PORT_A_LOW); // RL18
    assign pb_if.level = port_b_level_in;
    assign pb_if.change_en = port_b_change_en_in;
    assign pb_if.is_output = port_b_is_output_in;
    assign pb_if.read_clear = rd_hit && (addr_in == UIB_ADDR_PORT_B_LOW); // RL18

    uib_pin_change #(.PRESENT(UIB_PINS_A)) u_port_a (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .pins(pa_if.detector)
    );

    uib_pin_change #(.PRESENT(UIB_PINS_B)) u_port_b (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .pins(pb_if.detector)
    );

    // Bid registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bid_break_change_reg <= UIB_BID_RESET;
            bid_pin_change_reg <= UIB_BID_RESET;
            bid_timer_event_reg <= UIB_BID_RESET;
            bid_flow_control_reg <= UIB_BID_RESET;
            bid_address_match_reg <= UIB_BID_RESET;
            bid_loopback_error_reg <= UIB_BID_RESET;
        end else if (wr_hit) begin
            case (addr_in)
                UIB_ADDR_BID_BREAK: begin
                    bid_break_change_reg <= wdata_in; // RL11
                end
                UIB_ADDR_BID_PIN: begin
                    bid_pin_change_reg <= wdata_in; // RL11
                end
                UIB_ADDR_BID_TIMER: begin
                    bid_timer_event_reg <= wdata_in; // RL12
                end
                UIB_ADDR_BID_FLOW: begin
                    bid_flow_control_reg <= wdata_in; // RL11
                end
                UIB_ADDR_BID_ADDR: begin
                    bid_address_match_reg <= wdata_in; // RL11
                end
                UIB_ADDR_BID_LOOP: begin
                    bid_loopback_error_reg <= wdata_in; // RL11
                end
                default: ;
            endcase
        end
    end

    // Request and bid per source
    always_comb begin
        req = '0;
        req[UIB_SRC_RX] = rx_pend_in;
        req[UIB_SRC_TX] = tx_pend_in;
        req[UIB_SRC_PIN] = pin_event_reg;
        req[UIB_SRC_ADDR] = addr_pend_in;
        req[UIB_SRC_FLOW] = flow_pend_in;
        req[UIB_SRC_WDOG] = wdog_pend_in;
        req[UIB_SRC_BREAK] = break_pend_in;
        req[UIB_SRC_TIMER0] = timer_pend_in[0];
        req[UIB_SRC_TIMER1] = timer_pend_in[1];
        req[UIB_SRC_LOOP] = loop_pend_in;
        bid[UIB_SRC_RX] = rx_bid_in;
        bid[UIB_SRC_TX] = tx_bid_in;
        bid[UIB_SRC_WDOG] = rx_bid_in;
        bid[UIB_SRC_PIN] = {bid_pin_change_reg, UIB_LOW_BID}; // RL17
        bid[UIB_SRC_ADDR] = {bid_address_match_reg, UIB_LOW_BID}; // RL17
        bid[UIB_SRC_FLOW] = {bid_flow_control_reg, UIB_LOW_BID}; // RL17
        bid[UIB_SRC_BREAK] = {bid_break_change_reg, UIB_LOW_BID}; // RL17
        bid[UIB_SRC_TIMER0] = {bid_timer_event_reg, UIB_LOW_BID}; // RL12
        bid[UIB_SRC_TIMER1] = {bid_timer_event_reg, UIB_LOW_BID_T1}; // RL12
        bid[UIB_SRC_LOOP] = {bid_loopback_error_reg, UIB_LOW_BID}; // RL17
    end

    // Highest pending bid wins; ties go to the lower source index
    always_comb begin
        best_bid = '0;
        best_src = UIB_SRC_RX;
        best_valid = 1'b0;
        for (int s = 0; s < UIB_NSRC; s++) begin
            if (req[s] && (!best_valid || bid[s] > best_bid)) begin
                best_bid = bid[s]; // RL17
                best_src = uib_src_t'(s);
                best_valid = 1'b1;
            end
        end
    end

    // Kind code of the winner
    always_comb begin
        kind_next = 8'h00;
        channel_next = 1'b0;
        if (best_valid) begin
            case (best_src)
                UIB_SRC_RX: begin
                    kind_next[UIB_KIND_RX_MSB:UIB_KIND_RX_LSB] =
                        rx_err_in ? UIB_RX_WITH_ERR : UIB_RX_NO_ERR; // RL1
                end
                UIB_SRC_TX: begin
                    kind_next[UIB_KIND_TX_BIT] = 1'b1; // RL2
                end
                UIB_SRC_PIN: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_PIN; // RL3
                end
                UIB_SRC_ADDR: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_ADDR; // RL3
                end
                UIB_SRC_FLOW: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_FLOW; // RL3
                end
                UIB_SRC_WDOG: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_WDOG; // RL3
                end
                UIB_SRC_BREAK: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_BREAK; // RL3
                end
                UIB_SRC_TIMER0: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_TIMER; // RL3
                end
                UIB_SRC_TIMER1: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_TIMER; // RL3
                    channel_next = 1'b1;
                end
                UIB_SRC_LOOP: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_LOOP; // RL3
                end
                default: begin
                    kind_next[UIB_KIND_OTHER_MSB:0] = UIB_OTHER_NONE;
                end
            endcase
        end
    end

    // Acknowledge cycle start is the falling edge of the acknowledge strobe
    assign latch_now = (iack_prev_reg & ~interrupt_acknowledge_n_in) |
        (wr_hit && (addr_in == UIB_ADDR_UPDATE_CTX)); // RL16

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            iack_prev_reg <= 1'b1;
        end else begin
            iack_prev_reg <= interrupt_acknowledge_n_in;
        end
    end

    // Latched context stays frozen until the next latch
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            kind_reg <= 8'h00;
            channel_reg <= 1'b0;
        end else if (latch_now) begin
            kind_reg <= kind_next; // RL4
            channel_reg <= channel_next; // RL16
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_event_reg <= 1'b0;
        end else begin
            pin_event_reg <= (|pa_if.flags) | (|pb_if.flags);
        end
    end

    // Mask for the configured character length
    always_comb begin
        case (char_len_in)
            UIB_LEN5: char_mask = 8'h1F;
            UIB_LEN6: char_mask = 8'h3F;
            UIB_LEN7: char_mask = 8'h7F;
            default: char_mask = 8'hFF;
        endcase
    end

    // Read data path, one cycle after the read strobe
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_reg <= UIB_DATA_RESET;
        end else if (rd_hit) begin
            case (addr_in)
                UIB_ADDR_PORT_A_LOW: begin
                    rdata_reg <= {pa_if.flags, pa_if.levels}; // RL13
                end
                UIB_ADDR_PORT_B_LOW: begin
                    rdata_reg <= {pb_if.flags, pb_if.levels}; // RL15
                end
                UIB_ADDR_BID_BREAK: begin
                    rdata_reg <= bid_break_change_reg;
                end
                UIB_ADDR_BID_PIN: begin
                    rdata_reg <= bid_pin_change_reg;
                end
                UIB_ADDR_BID_TIMER: begin
                    rdata_reg <= bid_timer_event_reg;
                end
                UIB_ADDR_BID_FLOW: begin
                    rdata_reg <= bid_flow_control_reg;
                end
                UIB_ADDR_BID_ADDR: begin
                    rdata_reg <= bid_address_match_reg;
                end
                UIB_ADDR_BID_LOOP: begin
                    rdata_reg <= bid_loopback_error_reg;
                end
                UIB_ADDR_KIND: begin
                    rdata_reg <= kind_reg; // RL4
                end
                UIB_ADDR_DATA_PORT: begin
                    rdata_reg <= rx_data_in & char_mask; // RL5 RL7 RL6
                end
                default: begin
                    rdata_reg <= UIB_DATA_RESET;
                end
            endcase
        end
    end

    // FIFO strobes of the shared data port
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_pop_reg <= 1'b0;
            tx_push_reg <= 1'b0;
            tx_data_reg <= UIB_DATA_RESET;
        end else begin
            rx_pop_reg <= rd_hit && (addr_in == UIB_ADDR_DATA_PORT); // RL10 RL5
            tx_push_reg <= wr_hit && (addr_in == UIB_ADDR_DATA_PORT); // RL10 RL8
            if (wr_hit && (addr_in == UIB_ADDR_DATA_PORT)) begin
                tx_data_reg <= wdata_in & char_mask; // RL8
            end
        end
    end

    assign rdata_out = rdata_reg;
    assign rx_pop_out = rx_pop_reg;
    assign tx_push_out = tx_push_reg;
    assign tx_data_out = tx_data_reg;
    assign context_channel_out = channel_reg;
    assign current_interrupt_kind_out = kind_reg;
    assign pin_change_event_out = pin_event_reg;

endmodule

// >>> testbench/uib_chk.sv
module uib_chk
    import uib_pkg::*;
(
    // Bus
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cs_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic interrupt_acknowledge_n_in,
    input wire logic [7:0] rdata_out,
    // Channel and status
    input wire logic [7:0] rx_data_in,
    input wire logic [1:0] char_len_in,
    input wire logic rx_pop_out,
    input wire logic tx_push_out,
    input wire logic [7:0] tx_data_out,
    input wire logic [7:0] current_interrupt_kind_out,
    input wire logic [3:0] port_a_change_en_in,
    input wire logic [3:0] port_a_is_output_in
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    logic ack_q;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            ack_q <= 1'b1;
        else
            ack_q <= interrupt_acknowledge_n_in;
    end
    a_pop_on_read: assert property (cs_in && rd_in && addr_in == UIB_ADDR_DATA_PORT |=> rx_pop_out)
        else $error("no pop after data port read");
    a_pop_cause: assert property (rx_pop_out |-> $past(cs_in && rd_in && addr_in == UIB_ADDR_DATA_PORT))
        else $error("pop without data port read");
    a_push_on_write: assert property (cs_in && wr_in && addr_in == UIB_ADDR_DATA_PORT |=> tx_push_out && !rx_pop_out
        && tx_data_out == ($past(wdata_in) & (8'hFF >> (2'h3 - $past(char_len_in)))))
        else $error("bad push after data port write");
    a_rx_masked: assert property (rx_pop_out |-> rdata_out == ($past(rx_data_in) & (8'hFF >> (2'h3 - $past(char_len_in)))))
        else $error("receive data not masked");
    a_kind_legal: assert property (current_interrupt_kind_out inside {8'h00, 8'h80, 8'hC0, 8'h20, [8'h01:8'h07]})
        else $error("illegal kind value");
    a_kind_frozen: assert property ($changed(current_interrupt_kind_out) |-> $past((ack_q && !interrupt_acknowledge_n_in)
        || (cs_in && wr_in && addr_in == UIB_ADDR_UPDATE_CTX)))
        else $error("kind changed without latch");
    a_b_reserved: assert property (cs_in && rd_in && addr_in == UIB_ADDR_PORT_B_LOW |=> !rdata_out[5] && !rdata_out[1])
        else $error("port b reserved bit set");
    a_flag_hidden: assert property (cs_in && rd_in && addr_in == UIB_ADDR_PORT_A_LOW
        |=> (rdata_out[7:4] & ~$past(port_a_change_en_in & ~port_a_is_output_in)) == 4'h0)
        else $error("hidden change flag visible");
    a_rdata_holds: assert property (!(cs_in && rd_in) |=> $stable(rdata_out))
        else $error("read data moved without read");
endmodule

// >>> testbench/uib_fifo_model.sv
module uib_fifo_model (
    // Clock
    input wire logic clk_in,
    // Channel side
    input wire logic rx_pop_in,
    input wire logic tx_push_in,
    input wire logic [7:0] tx_data_in,
    output logic [7:0] rx_head_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int pops = 0;
    int pushes = 0;
    logic [7:0] tx_last = 8'h00;
    // Receive head advances on each pop
    assign rx_head_out = 8'hA5 ^ (8'(pops) * 8'h3B);
    always @(posedge clk_in) begin
        if (rx_pop_in)
            pops <= pops + 1;
        if (tx_push_in) begin
            pushes <= pushes + 1;
            tx_last <= tx_data_in;
        end
    end
endmodule

// >>> testbench/uib_context_bids_tb.sv
module uib_context_bids_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import uib_pkg::*;
    logic clk_in = 0, reset_n_in = 0, cs_in = 0, rd_in = 0, wr_in = 0, interrupt_acknowledge_n_in = 1;
    logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, tx_data_out, current_interrupt_kind_out, rx_data_in;
    logic [1:0] char_len_in = 3, timer_pend_in = 0;
    logic rx_pop_out, tx_push_out, context_channel_out, pin_change_event_out;
    logic rx_pend_in = 0, rx_err_in = 0, tx_pend_in = 0, addr_pend_in = 0, flow_pend_in = 0;
    logic wdog_pend_in = 0, break_pend_in = 0, loop_pend_in = 0;
    logic [9:0] rx_bid_in = 10'h100, tx_bid_in = 10'h0C0;
    logic [3:0] port_a_level_in = 0, port_a_change_en_in = 0, port_a_is_output_in = 0, fa, fb;
    logic [3:0] port_b_level_in = 0, port_b_change_en_in = 0, port_b_is_output_in = 0;
    logic [7:0] d, v, t;
    logic [7:0] kinds [11] = '{8'hC0, 8'h80, 8'h20, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h06, 8'h07, 8'h00};
    int mismatches = 0, checked = 0, seed = 89, n_rx = 0;
    uib_context_bids dut_u (.*);
    uib_fifo_model fm_u (.clk_in(clk_in), .rx_pop_in(rx_pop_out), .tx_push_in(tx_push_out),
        .tx_data_in(tx_data_out), .rx_head_out(rx_data_in));
    always #12.5 clk_in = ~clk_in;
    function automatic logic [7:0] msk(input logic [1:0] l);
        return 8'hFF >> (2'h3 - l);
    endfunction
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q);
        @(negedge clk_in);
        {cs_in, rd_in, wr_in} = {1'b1, !w, w};
        addr_in = a;
        wdata_in = wd;
        @(negedge clk_in);
        {cs_in, rd_in, wr_in} = 3'h0;
        q = rdata_out;
    endtask
    task automatic latch(input logic by_ack);
        logic [7:0] q;
        if (by_ack) begin
            @(negedge clk_in);
            interrupt_acknowledge_n_in = 0;
            @(negedge clk_in);
            interrupt_acknowledge_n_in = 1;
        end else
            bus(1, UIB_ADDR_UPDATE_CTX, 8'($random(seed)), q);
    endtask
    task automatic set_pend(input int i);
        {rx_pend_in, rx_err_in, tx_pend_in, addr_pend_in, flow_pend_in} = 5'h00;
        {wdog_pend_in, break_pend_in, timer_pend_in, loop_pend_in} = 5'h00;
        case (i)
            0: rx_pend_in = 1;
            1: {rx_pend_in, rx_err_in} = 2'h3;
            2: tx_pend_in = 1;
            3: addr_pend_in = 1;
            4: flow_pend_in = 1;
            5: wdog_pend_in = 1;
            6: break_pend_in = 1;
            7: timer_pend_in = 2'h1;
            8: timer_pend_in = 2'h2;
            9: loop_pend_in = 1;
            default: ;
        endcase
        repeat (3) @(negedge clk_in);
    endtask
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_in);
        reset_n_in = 1;
        for (int i = 0; i < 6; i++) begin
            bus(0, UIB_ADDR_BID_BREAK + 8'(i), 0, d);
            chk(UIB_BID_RESET, d);
            v = 8'($random(seed));
            bus(1, UIB_ADDR_BID_BREAK + 8'(i), v, d);
            bus(0, UIB_ADDR_BID_BREAK + 8'(i), 0, d);
            chk(v, d);
        end
        bus(0, UIB_ADDR_UPDATE_CTX, 0, d);
        chk(8'h00, d);
        $display("bid registers done");
        for (int i = 0; i < 11; i++) begin
            set_pend(i);
            latch(i[0]);
            chk(kinds[i], current_interrupt_kind_out);
            chk({7'h0, i == 8}, {7'h0, context_channel_out});
        end
        $display("kind codes done");
        for (int k = 0; k < 6; k++) begin
            set_pend(6);
            timer_pend_in = (k == 0) ? 2'h1 : 2'h3;
            v = 8'($random(seed));
            t = (k == 0) ? v : 8'($random(seed));
            bus(1, UIB_ADDR_BID_BREAK, v, d);
            bus(1, UIB_ADDR_BID_TIMER, t, d);
            latch(k[0]);
            chk((v > t || k == 0) ? 8'h05 : 8'h06, current_interrupt_kind_out);
            chk({7'h0, !(v > t || k == 0)}, {7'h0, context_channel_out});
        end
        $display("arbitration done");
        set_pend(0);
        latch(1);
        for (int l = 0; l < 4; l++) begin
            char_len_in = 2'(l);
            bus(0, UIB_ADDR_DATA_PORT, 0, d);
            chk((8'hA5 ^ (8'(n_rx) * 8'h3B)) & msk(2'(l)), d);
            n_rx++;
        end
        set_pend(2);
        latch(0);
        for (int l = 0; l < 4; l++) begin
            char_len_in = 2'(l);
            v = 8'($random(seed));
            bus(1, UIB_ADDR_DATA_PORT, v, d);
            @(negedge clk_in);
            chk(v & msk(2'(l)), fm_u.tx_last);
        end
        chk(8'h04, 8'(fm_u.pushes));
        chk(8'(n_rx), 8'(fm_u.pops));
        $display("data port done");
        set_pend(10);
        for (int k = 0; k < 6; k++) begin
            {port_a_change_en_in, port_a_is_output_in} = (k == 0) ? 8'hF0 : 8'($random(seed));
            {port_b_change_en_in, port_b_is_output_in} = (k == 0) ? 8'hF0 : 8'($random(seed));
            repeat (3) @(negedge clk_in);
            bus(0, UIB_ADDR_PORT_A_LOW, 0, d);
            bus(0, UIB_ADDR_PORT_B_LOW, 0, d);
            v = (k == 0) ? 8'hFF : 8'($random(seed));
            port_a_level_in ^= v[7:4];
            port_b_level_in ^= v[3:0];
            repeat (3) @(negedge clk_in);
            fa = v[7:4] & port_a_change_en_in & ~port_a_is_output_in;
            fb = v[3:0] & port_b_change_en_in & ~port_b_is_output_in & UIB_PINS_B;
            chk({7'h0, |{fa, fb}}, {7'h0, pin_change_event_out});
            latch(k[0]);
            chk((|{fa, fb}) ? 8'h01 : 8'h00, current_interrupt_kind_out);
            bus(0, UIB_ADDR_PORT_A_LOW, 0, d);
            chk({fa, port_a_level_in}, d);
            bus(0, UIB_ADDR_PORT_B_LOW, 0, d);
            chk({fb, port_b_level_in & UIB_PINS_B}, d);
            bus(0, UIB_ADDR_PORT_A_LOW, 0, d);
            chk({4'h0, port_a_level_in}, d);
            @(negedge clk_in);
            chk(8'h00, {7'h0, pin_change_event_out});
        end
        $display("port change done");
        reset_n_in = 0;
        repeat (2) @(negedge clk_in);
        reset_n_in = 1;
        repeat (3) @(negedge clk_in);
        chk(8'h00, current_interrupt_kind_out);
        chk(8'h00, {7'h0, pin_change_event_out});
        bus(0, UIB_ADDR_BID_TIMER, 0, d);
        chk(UIB_BID_RESET, d);
        $display("mid-run reset done");
        final_report();
    end
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule
bind uib_context_bids uib_chk chk_u (.*);
